// *** dpsp_addr_counter.sv ***
`timescale 1ns/10ps
`default_nettype none

package dpsp_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 18;
	localparam int LANE_W = 9;
	localparam int LANES = 2;
	localparam int PORTS = 2;
	localparam int DEPTH = 262144;
	localparam int LOWER_LANE = 0;
	localparam int UPPER_LANE = 1;
	localparam int TOP_ADDR_BIT = 17;
	localparam logic [17:0] ADDR_RST = 18'h00000;
	localparam logic [17:0] ADDR_ONE = 18'h00001;
	localparam logic [17:0] HALF_MASK = 18'h1FFFF;
	localparam logic [17:0] FULL_MASK = 18'h3FFFF;
	localparam logic [17:0] DATA_RST = 18'h00000;
	localparam logic [1:0] LANES_OFF = 2'h0;
endpackage : dpsp_pkg

module dpsp_addr_counter (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic half_depth,
	input wire logic address_load_strobe_n,
	input wire logic counter_advance_enable_n,
	input wire logic rewind_n,
	input wire logic [dpsp_pkg::ADDR_W-1:0] ext_addr,
	output logic [dpsp_pkg::ADDR_W-1:0] addr_used,
	output logic [dpsp_pkg::ADDR_W-1:0] addr_cur
);
	logic [dpsp_pkg::ADDR_W-1:0] cnt_ff;
	logic [dpsp_pkg::ADDR_W-1:0] rewind_ff;
	logic [dpsp_pkg::ADDR_W-1:0] nxt_cnt;
	logic [dpsp_pkg::ADDR_W-1:0] mask;

	assign mask = half_depth ? dpsp_pkg::HALF_MASK : dpsp_pkg::FULL_MASK;

	// rewind beats load beats advance; nothing here looks at the selects
	always_comb begin
		if (!rewind_n) begin
			nxt_cnt = rewind_ff;
		end else if (!address_load_strobe_n) begin
			nxt_cnt = ext_addr;
		end else if (!counter_advance_enable_n) begin
			nxt_cnt = cnt_ff + dpsp_pkg::ADDR_ONE;
		end else begin
			nxt_cnt = cnt_ff;
		end
	end

	assign addr_used = nxt_cnt & mask;
	assign addr_cur = cnt_ff;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= dpsp_pkg::ADDR_RST;
		end else begin
			cnt_ff <= addr_used;
		end
	end

	// no reset on purpose: the rewind target is unknown until the first load
	always_ff @(posedge ref_clk) begin
		if (rewind_n && !address_load_strobe_n) begin
			rewind_ff <= ext_addr & mask;
		end
	end
endmodule : dpsp_addr_counter

`default_nettype wire

// *** dpsp_dual_port.sv ***
// Operation
// - a clocked write with both chip selects active stores only the lanes whose select is low; otherwise the port is deselected.
// - a clocked read with both chip selects active and output enable low drives only the selected lanes.
// - the upper lane select governs data bits 9 to 17 and the lower one bits 0 to 8.
// - output enable acts without the clock and high forces every data output off.
// - pipelined mode presents read data one cycle later than flow-through mode.
// - in pipelined mode chip and lane selects are registered twice, so deselect lands after two cycles.
// - load strobe low with rewind high loads and uses the external address whatever the selects.
// - load high, rewind high and advance low increments the internal address and ignores the external one.
// - the counter advances on advance low even when the port is deselected.
// - load, advance and rewind all high reuse the previous internal address.
// - rewind low returns the counter to the last loaded address, ahead of load and advance.
// - each load overwrites the rewind target, which is unknown after power-up.
`timescale 1ns/10ps
`default_nettype none

module dpsp_dual_port #(
	parameter logic HALF_DEPTH = 1'b0
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic p0_chip_select_active_low_n,
	input wire logic p0_chip_select_active_high,
	input wire logic p0_read_write,
	input wire logic p0_output_enable_n,
	input wire logic p0_upper_lane_select_n,
	input wire logic p0_lower_lane_select_n,
	input wire logic p0_latency_mode_pin,
	input wire logic p0_address_load_strobe_n,
	input wire logic p0_counter_advance_enable_n,
	input wire logic p0_rewind_n,
	input wire logic [17:0] p0_addr,
	input wire logic [17:0] p0_dq_in,
	output logic [17:0] p0_dq_out,
	output logic [1:0] p0_dq_oe,
	input wire logic p1_chip_select_active_low_n,
	input wire logic p1_chip_select_active_high,
	input wire logic p1_read_write,
	input wire logic p1_output_enable_n,
	input wire logic p1_upper_lane_select_n,
	input wire logic p1_lower_lane_select_n,
	input wire logic p1_latency_mode_pin,
	input wire logic p1_address_load_strobe_n,
	input wire logic p1_counter_advance_enable_n,
	input wire logic p1_rewind_n,
	input wire logic [17:0] p1_addr,
	input wire logic [17:0] p1_dq_in,
	output logic [17:0] p1_dq_out,
	output logic [1:0] p1_dq_oe
);
	localparam int NP = dpsp_pkg::PORTS;
	localparam int AW = dpsp_pkg::ADDR_W;
	localparam int DW = dpsp_pkg::DATA_W;
	localparam int LW = dpsp_pkg::LANE_W;

	logic [DW-1:0] mem [dpsp_pkg::DEPTH];

	logic [NP-1:0] cs_lo_n;
	logic [NP-1:0] cs_hi;
	logic [NP-1:0] rw;
	logic [NP-1:0] oe_n;
	logic [NP-1:0] pipe;
	logic [NP-1:0] load_n;
	logic [NP-1:0] adv_n;
	logic [NP-1:0] rewind_n;
	logic [1:0] lane_n [NP];
	logic [AW-1:0] addr_in [NP];
	logic [DW-1:0] din [NP];
	logic [AW-1:0] addr_used [NP];
	logic [AW-1:0] addr_cur [NP];
	logic [NP-1:0] sel;
	logic [1:0] wr_now [NP];
	logic [1:0] rd_now [NP];
	logic [1:0] rd1_ff [NP];
	logic [1:0] lane_rd_ff [NP];
	logic [DW-1:0] data1_ff [NP];
	logic [DW-1:0] out_ff [NP];
	logic [1:0] dq_oe [NP];

	// all properties share the one clock and stay quiet during reset
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	assign cs_lo_n = {p1_chip_select_active_low_n, p0_chip_select_active_low_n};
	assign cs_hi = {p1_chip_select_active_high, p0_chip_select_active_high};
	assign rw = {p1_read_write, p0_read_write};
	assign oe_n = {p1_output_enable_n, p0_output_enable_n};
	assign pipe = {p1_latency_mode_pin, p0_latency_mode_pin};
	assign load_n = {p1_address_load_strobe_n, p0_address_load_strobe_n};
	assign adv_n = {p1_counter_advance_enable_n, p0_counter_advance_enable_n};
	assign rewind_n = {p1_rewind_n, p0_rewind_n};
	assign lane_n[0] = {p0_upper_lane_select_n, p0_lower_lane_select_n};
	assign lane_n[1] = {p1_upper_lane_select_n, p1_lower_lane_select_n};
	assign addr_in[0] = p0_addr;
	assign addr_in[1] = p1_addr;
	assign din[0] = p0_dq_in;
	assign din[1] = p1_dq_in;
	assign p0_dq_out = out_ff[0];
	assign p1_dq_out = out_ff[1];
	assign p0_dq_oe = dq_oe[0];
	assign p1_dq_oe = dq_oe[1];

	////////////////////////////////////////////////////////////////////////////////
	// shared array: both ports may write one word in the same cycle; port 1 is written last and its lanes win
	always_ff @(posedge ref_clk) begin
		for (int p = 0; p < NP; p++) begin
			for (int l = 0; l < dpsp_pkg::LANES; l++) begin
				if (wr_now[p][l]) begin
					mem[addr_used[p]][l*LW +: LW] <= din[p][l*LW +: LW];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	for (genvar g = 0; g < NP; g++) begin : g_port
		dpsp_addr_counter u_cnt (
			.ref_clk(ref_clk),
			.rst(rst),
			.half_depth(HALF_DEPTH),
			.address_load_strobe_n(load_n[g]),
			.counter_advance_enable_n(adv_n[g]),
			.rewind_n(rewind_n[g]),
			.ext_addr(addr_in[g]),
			.addr_used(addr_used[g]),
			.addr_cur(addr_cur[g])
		);

		assign sel[g] = !cs_lo_n[g] && cs_hi[g];
		assign wr_now[g] = (sel[g] && !rw[g]) ? ~lane_n[g] : dpsp_pkg::LANES_OFF;
		assign rd_now[g] = (sel[g] && rw[g]) ? ~lane_n[g] : dpsp_pkg::LANES_OFF;

		// first select stage, only used in pipelined mode
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				rd1_ff[g] <= dpsp_pkg::LANES_OFF;
				data1_ff[g] <= dpsp_pkg::DATA_RST;
			end else begin
				rd1_ff[g] <= rd_now[g];
				data1_ff[g] <= mem[addr_used[g]];
			end
		end

		// output stage: flow-through reads straight from the array, pipeline adds a stage
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				lane_rd_ff[g] <= dpsp_pkg::LANES_OFF;
				out_ff[g] <= dpsp_pkg::DATA_RST;
			end else if (pipe[g]) begin
				lane_rd_ff[g] <= rd1_ff[g];
				out_ff[g] <= data1_ff[g];
			end else begin
				lane_rd_ff[g] <= rd_now[g];
				out_ff[g] <= mem[addr_used[g]];
			end
		end

		// output enable bypasses the clock so the bus releases at once
		assign dq_oe[g] = oe_n[g] ? dpsp_pkg::LANES_OFF : lane_rd_ff[g];

		////////////////////////////////////////////////////////////////////////////////

		a_deselect_quiet: assert property (
			!pipe[g] && !sel[g] |=> lane_rd_ff[g] == 2'h0
		) else $error("deselected flow-through port still reads");
		a_read_lanes: assert property (
			!pipe[g] && sel[g] && rw[g] |=> lane_rd_ff[g] == ~$past(lane_n[g])
		) else $error("read lanes do not follow lane selects");
		a_oe_async: assert property (
			oe_n[g] |-> dq_oe[g] == 2'h0
		) else $error("data driven while output enable high");
		a_pipe_delay: assert property (
			pipe[g] && sel[g] && rw[g] ##1 pipe[g]
			|=> lane_rd_ff[g] == ~$past(lane_n[g], 2)
		) else $error("pipelined read not one cycle later");
		a_double_desel: assert property (
			pipe[g] && sel[g] && rw[g] ##1 pipe[g] && !sel[g] ##1 pipe[g]
			|-> lane_rd_ff[g] == ~$past(lane_n[g], 2) ##1 lane_rd_ff[g] == 2'h0
		) else $error("pipelined deselect not two cycles");
		a_load_addr: assert property (
			rewind_n[g] && !load_n[g] |-> addr_used[g] == (addr_in[g] & (HALF_DEPTH ?
				dpsp_pkg::HALF_MASK : dpsp_pkg::FULL_MASK))
		) else $error("external address not loaded");
		a_advance_addr: assert property (
			rewind_n[g] && load_n[g] && !adv_n[g] |-> addr_used[g] == ((addr_cur[g] +
				dpsp_pkg::ADDR_ONE) & (HALF_DEPTH ? dpsp_pkg::HALF_MASK : dpsp_pkg::FULL_MASK))
		) else $error("counter did not advance");
		a_hold_addr: assert property (
			rewind_n[g] && load_n[g] && adv_n[g] |=> addr_cur[g] == $past(addr_cur[g])
		) else $error("held address changed");
		a_rewind_addr: assert property (
			rewind_n[g] && !load_n[g] && !HALF_DEPTH ##1 !rewind_n[g]
			|-> addr_used[g] == $past(addr_in[g])
		) else $error("rewind did not return to last load");
		// array checks only hold while the other port leaves the word alone
		a_write_lower: assert property (
			sel[g] && !rw[g] && !lane_n[g][0] && wr_now[NP-1-g] == dpsp_pkg::LANES_OFF
			|=> mem[$past(addr_used[g])][LW-1:0] == $past(din[g][LW-1:0])
		) else $error("selected lower lane not written");
		a_keep_upper: assert property (
			sel[g] && !rw[g] && lane_n[g][1] && wr_now[NP-1-g] == dpsp_pkg::LANES_OFF
			|=> mem[$past(addr_used[g])][DW-1:LW] == $past(mem[addr_used[g]][DW-1:LW])
		) else $error("unselected upper lane changed");
		a_flow_data: assert property (
			!pipe[g] && sel[g] && rw[g] |=> out_ff[g] == $past(mem[addr_used[g]])
		) else $error("flow-through word not shown next cycle");
		a_pipe_data: assert property (
			pipe[g] && sel[g] && rw[g] ##1 pipe[g]
			|=> out_ff[g] == $past(mem[addr_used[g]], 2)
		) else $error("pipelined word not shown two cycles on");

		c_write_both: cover property (sel[g] && !rw[g] && lane_n[g] == 2'h0);
		c_pipe_read: cover property (pipe[g] && sel[g] && rw[g] ##2 dq_oe[g] != 2'h0);
		c_rewind: cover property (!load_n[g] && rewind_n[g] ##[1:4] !rewind_n[g]);
		c_lower_write: cover property (sel[g] && !rw[g] && lane_n[g] == 2'h2);
	end : g_port
endmodule : dpsp_dual_port

`default_nettype wire

// *** dpsp_host.sv ***
`timescale 1ns/10ps
`default_nettype none

// bus master for one port; every request is driven just after a rising edge
module dpsp_host #(
	parameter logic PIPE = 1'b0
) (
	input wire logic ref_clk,
	output logic [45:0] pins
);
	// cs_n, cs, rw, oe_n, ub_n, lb_n, ld_n, adv_n, rew_n
	logic [8:0] ctl;
	logic [17:0] addr;
	logic [17:0] dq;

	// deselected and holding, rewind idle until a load has been made
	initial begin
		ctl = 9'h15F;
		addr = 18'h00000;
		dq = 18'h00000;
	end

	assign pins = {ctl[8:3], PIPE, ctl[2:0], addr, dq};

	////////////////////////////////////////
	// write data off a write keeps toggling so a stale word never looks valid
	task automatic access(input logic sel, input logic r, input logic [1:0] ln,
		input logic [2:0] c, input logic [17:0] a, input logic [17:0] d);
		@(posedge ref_clk);
		ctl <= {~sel, sel, r, ctl[5], ln, c};
		addr <= a;
		dq <= r ? ~dq : d;
	endtask : access

	task automatic set_oe(input logic v);
		@(posedge ref_clk);
		ctl[5] <= v;
	endtask : set_oe
endmodule : dpsp_host

`default_nettype wire

// *** dual_port_sync_sram_port_bench.sv ***
`timescale 1ns/10ps
`default_nettype none

module dual_port_sync_sram_port_bench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [45:0] b0, b1;
	logic [17:0] o0, o1, a, d0, d1, d2, d3;
	logic [1:0] e0, e1;
	logic [51:0] q0[$], q1[$];
	int cyc = 0, num_errors = 0, comparisons = 0;

	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;

	dpsp_host #(.PIPE(1'b0)) h0 (.ref_clk, .pins(b0));
	dpsp_host #(.PIPE(1'b1)) h1 (.ref_clk, .pins(b1));

	dpsp_dual_port uut (.ref_clk, .rst,
		.p0_chip_select_active_low_n(b0[45]), .p0_chip_select_active_high(b0[44]),
		.p0_read_write(b0[43]), .p0_output_enable_n(b0[42]), .p0_upper_lane_select_n(b0[41]),
		.p0_lower_lane_select_n(b0[40]), .p0_latency_mode_pin(b0[39]),
		.p0_address_load_strobe_n(b0[38]), .p0_counter_advance_enable_n(b0[37]),
		.p0_rewind_n(b0[36]), .p0_addr(b0[35:18]), .p0_dq_in(b0[17:0]),
		.p0_dq_out(o0), .p0_dq_oe(e0),
		.p1_chip_select_active_low_n(b1[45]), .p1_chip_select_active_high(b1[44]),
		.p1_read_write(b1[43]), .p1_output_enable_n(b1[42]), .p1_upper_lane_select_n(b1[41]),
		.p1_lower_lane_select_n(b1[40]), .p1_latency_mode_pin(b1[39]),
		.p1_address_load_strobe_n(b1[38]), .p1_counter_advance_enable_n(b1[37]),
		.p1_rewind_n(b1[36]), .p1_addr(b1[35:18]), .p1_dq_in(b1[17:0]),
		.p1_dq_out(o1), .p1_dq_oe(e1));

	////////////////////////////////////////
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : check

	task automatic report_and_stop;
		if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop

	// read request; the note holds {cycle seen, lanes driven, word}
	task automatic rd(input int p, input logic s, input logic [1:0] ln, input logic [2:0] c,
		input logic [17:0] ad, input logic [17:0] ex);
		logic [51:0] x;
		if (p == 0) h0.access(s, 1'b1, ln, c, ad, ex);
		else h1.access(s, 1'b1, ln, c, ad, ex);
		x = {cyc + 2 + p, ~ln, ex};
		if (s && p == 0) q0.push_back(x);
		if (s && p == 1) q1.push_back(x);
	endtask : rd

	// an output with no note pending fails on the lane compare
	task automatic take(input int p, input logic [1:0] e, input logic [17:0] o);
		logic [51:0] x;
		logic [17:0] m;
		x = 52'h0;
		if (p == 0 && q0.size() > 0) x = q0.pop_front();
		if (p == 1 && q1.size() > 0) x = q1.pop_front();
		m = {{9{e[1]}}, {9{e[0]}}};
		check("cycle", x[51:20], cyc);
		check("lanes", x[19:18], e);
		check("word", x[17:0] & m, o & m);
	endtask : take

	always @(negedge ref_clk) begin
		if (e0 !== 2'h0) take(0, e0, o0);
		if (e1 !== 2'h0) take(1, e1, o1);
	end

	////////////////////////////////////////
	initial begin
		void'($urandom(32'h6481));
		a = 18'($urandom) & 18'h0FFFF;
		d0 = 18'($urandom);
		d1 = 18'($urandom);
		d2 = 18'($urandom);
		d3 = 18'($urandom);
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		h0.access(1'b1, 1'b0, 2'h0, 3'h3, a, d1);
		h0.access(1'b1, 1'b0, 2'h0, 3'h5, 18'h00000, d0);
		h0.access(1'b1, 1'b0, 2'h2, 3'h7, 18'h3FFFF, d2);
		h0.access(1'b0, 1'b0, 2'h0, 3'h3, a, d3);
		rd(0, 1'b1, 2'h0, 3'h7, 18'h3FFFF, d1);
		rd(0, 1'b0, 2'h0, 3'h5, 18'h00000, d1);
		rd(0, 1'b1, 2'h0, 3'h7, 18'h00000, {d0[17:9], d2[8:0]});
		rd(0, 1'b1, 2'h1, 3'h2, a + 18'h00005, d1);
		rd(0, 1'b0, 2'h3, 3'h7, 18'h00000, 18'h00000);
		rd(1, 1'b1, 2'h2, 3'h3, a + 18'h00001, {d0[17:9], d2[8:0]});
		rd(1, 1'b0, 2'h0, 3'h7, a, d1);
		h0.set_oe(1'b1);
		h0.access(1'b1, 1'b1, 2'h0, 3'h3, a, d1);
		rd(0, 1'b0, 2'h3, 3'h7, 18'h00000, 18'h00000);
		h0.set_oe(1'b0);
		h0.access(1'b1, 1'b0, 2'h0, 3'h3, a + 18'h00005, d3);
		rd(0, 1'b1, 2'h0, 3'h6, 18'h00000, d3);
		rd(0, 1'b0, 2'h3, 3'h7, 18'h00000, 18'h00000);
		repeat (4) @(posedge ref_clk);
		check("pending", 32'h0, q0.size() + q1.size());
		report_and_stop();
	end

	// the sequence needs well under a hundred cycles
	initial begin
		repeat (2000) @(posedge ref_clk);
		num_errors++;
		report_and_stop();
	end
endmodule : dual_port_sync_sram_port_bench

`default_nettype wire
